// ==== fnd_consts.svh ====
`ifndef FND_CONSTS_SVH
`define FND_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FND_OFF_W0     8'h00
`define FND_OFF_W2     8'h08
`define FND_OFF_W3     8'h0C
`define FND_OFF_CTRL   8'h10
`define FND_OFF_STAT   8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define FND_W0_LSEL    15
`define FND_W2_RDIV    2
`define FND_W2_FRACT   18
`define FND_W2_MELO    20
`define FND_W3_MEHI    2
`define FND_W3_FN      13
`define FND_CTRL_N     0
`define FND_CTRL_P8    16
`define FND_ST_LOCK    0
`define FND_ST_P8      1
`define FND_ST_A       4
`define FND_ST_M       8
`define FND_FN_POS     15

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define FND_RST_LSEL   3'h0
`define FND_RST_RDIV   2'h3
`define FND_RST_FRACT  1'h1
`define FND_RST_N      10'h000
`define FND_INT_OFS    12'h003
`define FND_HALF       24'h400000
`define FND_LOCK_WIN   7'h20

// ----------------------------------------
// lock pin sources
// ----------------------------------------
`define FND_LS_LOCK    3'h0
`define FND_LS_REF     3'h1
`define FND_LS_FB      3'h2
`define FND_LS_TEST    3'h3

`endif

// ==== fnd_pkg.sv ====
package fnd_pkg;
  typedef logic [22:0] fnd_frac_t;
  typedef logic [9:0]  fnd_code_t;
  typedef logic [11:0] fnd_ratio_t;
  typedef enum logic {FND_PRE_16_17, FND_PRE_8_9} fnd_prescale_e;
endpackage : fnd_pkg

// ==== fnd_sdm_if.sv ====
`timescale 1ns/1ps
// controller to modulator link
interface fnd_sdm_if;
  logic              step;
  logic              enable;
  fnd_pkg::fnd_frac_t frac;
  logic [3:0]        offset;
  modport ctl (output step, output enable, output frac, input offset);
  modport mod (input step, input enable, input frac, output offset);
endinterface : fnd_sdm_if

// ==== fnd_sdm_mash.sv ====
`timescale 1ns/1ps
module fnd_sdm_mash
(
  input  wire logic   mclk_in,
  input  wire logic   arst_n_in,
  fnd_sdm_if.mod      sd
);

  logic [22:0] acc1_ff;
  logic [22:0] acc2_ff;
  logic [22:0] acc3_ff;
  logic        c2d_ff;
  logic        c3d_ff;
  logic        c3dd_ff;
  logic [3:0]  off_ff;
  logic [23:0] nxt_s1;
  logic [23:0] nxt_s2;
  logic [23:0] nxt_s3;
  logic [3:0]  nxt_off;

  // ----------------------------------------
  // three cascaded accumulators
  // ----------------------------------------
  always_comb
  begin
    nxt_s1  = {1'h0, acc1_ff} + {1'h0, sd.frac};
    nxt_s2  = {1'h0, acc2_ff} + {1'h0, nxt_s1[22:0]};
    nxt_s3  = {1'h0, acc3_ff} + {1'h0, nxt_s2[22:0]};
    // noise-cancel combine, range -3..+4
    nxt_off = {3'h0, nxt_s1[23]} + {3'h0, nxt_s2[23]} - {3'h0, c2d_ff}
            + {3'h0, nxt_s3[23]} - {2'h0, c3d_ff, 1'h0} + {3'h0, c3dd_ff};
  end

  // step once per reference cycle, cleared when idle
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      acc1_ff <= 23'h000000;
      acc2_ff <= 23'h000000;
      acc3_ff <= 23'h000000;
      c2d_ff  <= 1'h0;
      c3d_ff  <= 1'h0;
      c3dd_ff <= 1'h0;
      off_ff  <= 4'h0;
    end
    else if (!sd.enable)
    begin
      acc1_ff <= 23'h000000;
      acc2_ff <= 23'h000000;
      acc3_ff <= 23'h000000;
      c2d_ff  <= 1'h0;
      c3d_ff  <= 1'h0;
      c3dd_ff <= 1'h0;
      off_ff  <= 4'h0;
    end
    else if (sd.step)
    begin
      acc1_ff <= nxt_s1[22:0];
      acc2_ff <= nxt_s2[22:0];
      acc3_ff <= nxt_s3[22:0];
      c2d_ff  <= nxt_s2[23];
      c3d_ff  <= nxt_s3[23];
      c3dd_ff <= c3d_ff;
      off_ff  <= nxt_off;
    end
  end

  assign sd.offset = off_ff;

endmodule : fnd_sdm_mash

// ==== fnd_feedback_divider.sv ====
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "fnd_consts.svh"
module fnd_feedback_divider
(
  input  wire logic        mclk_in,
  input  wire logic        arst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        ref_clk_in,
  input  wire logic        presc_clk_in,
  input  wire logic        output_switch_enable_in,
  output logic             modulus_select_out,
  output logic             prescaler_mode_out,
  output logic             rf_switch_on_out,
  output logic             lock_indicator_pin_out
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [2:0]              lock_sel_ff;
  logic [1:0]              rdiv_ff;
  logic                    fract_mode_ff;
  logic [3:0]              me_lo_ff;
  logic [10:0]             me_hi_ff;
  logic [7:0]              fn_ff;
  fnd_pkg::fnd_code_t      ncode_ff;
  fnd_pkg::fnd_prescale_e  pmode_ff;
  fnd_pkg::fnd_code_t      act_n_ff;
  fnd_pkg::fnd_frac_t      act_frac_ff;
  fnd_pkg::fnd_prescale_e  act_pmode_ff;
  logic                    act_fract_ff;
  logic                    wr_pend_ff;
  logic                    rd_pend_ff;
  logic [7:0]              wr_addr_ff;
  logic [7:0]              rd_addr_ff;
  logic [31:0]             hrdata_ff;
  logic                    hreadyout_ff;
  logic                    hresp_ff;
  logic [2:0]              meta_ff;
  logic [2:0]              sync_ff;
  logic [1:0]              prev_ff;
  logic [2:0]              rcnt_ff;
  logic                    rdiv_prev_ff;
  logic                    ratio_upd_ff;
  logic [5:0]              m_ld_ff;
  logic [3:0]              a_ld_ff;
  logic [5:0]              m_cnt_ff;
  logic [3:0]              a_cnt_ff;
  logic                    modsel_ff;
  logic                    fb_wrap_ff;
  logic [6:0]              win_cnt_ff;
  logic [6:0]              fb_cnt_ff;
  logic                    locked_ff;
  logic                    lock_pin_ff;
  logic                    swen_ff;
  logic                    addr_ok;
  logic                    ref_rise;
  logic                    presc_rise;
  logic                    rdiv_lvl;
  logic                    ref_tick;
  logic [23:0]             frac_sum;
  fnd_pkg::fnd_ratio_t     nxt_ratio;
  logic                    nxt_lock_pin;

  fnd_sdm_if sd ();

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // integer ratio that the loaded code really gives
  function automatic fnd_pkg::fnd_code_t n_actual
  (
    input fnd_pkg::fnd_code_t     code,
    input fnd_pkg::fnd_prescale_e mode
  );
    if (mode == fnd_pkg::FND_PRE_8_9)
      n_actual = {1'h0, code[9:4], 3'h0} + {7'h00, code[2:0]};
    else
      n_actual = code;
  endfunction : n_actual

  // register read mux
  function automatic logic [31:0] rd_word
  (
    input logic [7:0] addr
  );
    rd_word = 32'h00000000;
    unique case (addr)
      `FND_OFF_W0:
        rd_word[`FND_W0_LSEL +: 3] = lock_sel_ff;
      `FND_OFF_W2:
      begin
        rd_word[`FND_W2_RDIV +: 2] = rdiv_ff;
        rd_word[`FND_W2_FRACT]     = fract_mode_ff;
        rd_word[`FND_W2_MELO +: 4] = me_lo_ff;
      end
      `FND_OFF_W3:
      begin
        rd_word[`FND_W3_MEHI +: 11] = me_hi_ff;
        rd_word[`FND_W3_FN +: 8]    = fn_ff;
      end
      `FND_OFF_CTRL:
      begin
        rd_word[`FND_CTRL_N +: 10] = ncode_ff;
        rd_word[`FND_CTRL_P8]      = pmode_ff;
      end
      `FND_OFF_STAT:
      begin
        rd_word[`FND_ST_LOCK]   = locked_ff;
        rd_word[`FND_ST_P8]     = act_pmode_ff;
        rd_word[`FND_ST_A +: 4] = a_ld_ff;
        rd_word[`FND_ST_M +: 6] = m_ld_ff;
      end
      default:
        rd_word = 32'h00000000;
    endcase
  endfunction : rd_word

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  assign addr_ok = hsel_in & hready_in & htrans_in[1];

  // address phase capture; reads take one wait state
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wr_pend_ff   <= 1'h0;
      rd_pend_ff   <= 1'h0;
      wr_addr_ff   <= 8'h00;
      rd_addr_ff   <= 8'h00;
      hreadyout_ff <= 1'h1;
      hresp_ff     <= 1'h0;
    end
    else
    begin
      wr_pend_ff   <= addr_ok & hwrite_in;
      rd_pend_ff   <= addr_ok & ~hwrite_in;
      hreadyout_ff <= ~(addr_ok & ~hwrite_in);
      hresp_ff     <= 1'h0;
      if (addr_ok)
      begin
        wr_addr_ff <= haddr_in[7:0];
        rd_addr_ff <= haddr_in[7:0];
      end
    end
  end

  // read data from the cycle after the wait cycle onward
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      hrdata_ff <= 32'h00000000;
    else if (rd_pend_ff)
      hrdata_ff <= rd_word(rd_addr_ff);
  end

  // register writes in the data phase
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lock_sel_ff   <= `FND_RST_LSEL;
      rdiv_ff       <= `FND_RST_RDIV;
      fract_mode_ff <= `FND_RST_FRACT;
      me_lo_ff      <= 4'h0;
      me_hi_ff      <= 11'h000;
      fn_ff         <= 8'h00;
      ncode_ff      <= `FND_RST_N;
      pmode_ff      <= fnd_pkg::FND_PRE_8_9;
    end
    else if (wr_pend_ff)
    begin
      unique case (wr_addr_ff)
        `FND_OFF_W0:
          lock_sel_ff <= hwdata_in[`FND_W0_LSEL +: 3];
        `FND_OFF_W2:
        begin
          rdiv_ff       <= hwdata_in[`FND_W2_RDIV +: 2];
          fract_mode_ff <= hwdata_in[`FND_W2_FRACT];
          me_lo_ff      <= hwdata_in[`FND_W2_MELO +: 4];
        end
        `FND_OFF_W3:
        begin
          me_hi_ff <= hwdata_in[`FND_W3_MEHI +: 11];
          fn_ff    <= hwdata_in[`FND_W3_FN +: 8];
        end
        `FND_OFF_CTRL:
        begin
          ncode_ff <= hwdata_in[`FND_CTRL_N +: 10];
          pmode_ff <= fnd_pkg::fnd_prescale_e'(hwdata_in[`FND_CTRL_P8]);
        end
        default:
          ncode_ff <= ncode_ff;
      endcase
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // bit 0 reference, bit 1 prescaler, bit 2 switch enable
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta_ff <= 3'h0;
      sync_ff <= 3'h0;
      prev_ff <= 2'h0;
    end
    else
    begin
      meta_ff <= {output_switch_enable_in, presc_clk_in, ref_clk_in};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff[1:0];
    end
  end

  assign ref_rise   = sync_ff[0] & ~prev_ff[0];
  assign presc_rise = sync_ff[1] & ~prev_ff[1];

  // ----------------------------------------
  // reference divider
  // ----------------------------------------
  // three halving stages as a ripple of counter bits
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rcnt_ff <= 3'h0;
    else if (ref_rise)
      rcnt_ff <= rcnt_ff + 3'h1;
  end

  // stage select and rising edge of the chosen output
  always_comb
  begin
    unique case (rdiv_ff)
      2'h0: rdiv_lvl = sync_ff[0];
      2'h1: rdiv_lvl = rcnt_ff[0];
      2'h2: rdiv_lvl = rcnt_ff[1];
      2'h3: rdiv_lvl = rcnt_ff[2];
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rdiv_prev_ff <= 1'h0;
    else
      rdiv_prev_ff <= rdiv_lvl;
  end

  assign ref_tick = rdiv_lvl & ~rdiv_prev_ff;

  // ----------------------------------------
  // active codes and modulator
  // ----------------------------------------
  // shadow codes move to the active set on a reference edge
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      act_n_ff     <= `FND_RST_N;
      act_frac_ff  <= 23'h000000;
      act_pmode_ff <= fnd_pkg::FND_PRE_8_9;
      act_fract_ff <= `FND_RST_FRACT;
    end
    else if (ref_tick)
    begin
      act_n_ff     <= ncode_ff;
      act_frac_ff  <= {fn_ff, me_hi_ff, me_lo_ff};
      act_pmode_ff <= pmode_ff;
      act_fract_ff <= fract_mode_ff;
    end
  end

  // half-step bias folded into the modulator input
  assign frac_sum  = {1'h0, act_frac_ff} + `FND_HALF;
  assign sd.step   = ref_tick;
  assign sd.enable = act_fract_ff;
  assign sd.frac   = frac_sum[22:0];

  fnd_sdm_mash u_sdm
  (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .sd        (sd.mod)
  );

  // instantaneous ratio for the next feedback period
  always_comb
  begin
    nxt_ratio = {2'h0, n_actual(act_n_ff, act_pmode_ff)} + `FND_INT_OFS;
    if (act_fract_ff)
      nxt_ratio = nxt_ratio + {11'h000, frac_sum[23]}
                + {{8{sd.offset[3]}}, sd.offset};
  end

  // split ratio into low and high counts, one cycle after the step
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ratio_upd_ff <= 1'h0;
      m_ld_ff      <= 6'h00;
      a_ld_ff      <= 4'h0;
    end
    else
    begin
      ratio_upd_ff <= ref_tick;
      if (ratio_upd_ff)
      begin
        if (act_pmode_ff == fnd_pkg::FND_PRE_8_9)
        begin
          m_ld_ff <= nxt_ratio[8:3];
          a_ld_ff <= {1'h0, nxt_ratio[2:0]};
        end
        else
        begin
          m_ld_ff <= nxt_ratio[9:4];
          a_ld_ff <= nxt_ratio[3:0];
        end
      end
    end
  end

  // ----------------------------------------
  // feedback counter
  // ----------------------------------------
  // m periods per cycle, the first a at the upper ratio
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      m_cnt_ff   <= 6'h00;
      a_cnt_ff   <= 4'h0;
      modsel_ff  <= 1'h0;
      fb_wrap_ff <= 1'h0;
    end
    else
    begin
      fb_wrap_ff <= 1'h0;
      if (presc_rise)
      begin
        if (m_cnt_ff <= 6'h01)
        begin
          m_cnt_ff   <= m_ld_ff;
          a_cnt_ff   <= a_ld_ff - {3'h0, a_ld_ff != 4'h0};
          modsel_ff  <= a_ld_ff != 4'h0;
          fb_wrap_ff <= 1'h1;
        end
        else
        begin
          m_cnt_ff  <= m_cnt_ff - 6'h01;
          a_cnt_ff  <= a_cnt_ff - {3'h0, a_cnt_ff != 4'h0};
          modsel_ff <= a_cnt_ff != 4'h0;
        end
      end
    end
  end

  // ----------------------------------------
  // frequency lock detect
  // ----------------------------------------
  // count feedback cycles across a window of reference cycles
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      win_cnt_ff <= 7'h00;
      fb_cnt_ff  <= 7'h00;
      locked_ff  <= 1'h0;
    end
    else if (ref_tick && win_cnt_ff == `FND_LOCK_WIN - 7'h01)
    begin
      win_cnt_ff <= 7'h00;
      fb_cnt_ff  <= {6'h00, fb_wrap_ff};
      locked_ff  <= fb_cnt_ff >= `FND_LOCK_WIN - 7'h01
                 && fb_cnt_ff <= `FND_LOCK_WIN + 7'h01;
    end
    else
    begin
      if (ref_tick)
        win_cnt_ff <= win_cnt_ff + 7'h01;
      if (fb_wrap_ff && fb_cnt_ff != 7'h7F)
        fb_cnt_ff <= fb_cnt_ff + 7'h01;
    end
  end

  // ----------------------------------------
  // output pins
  // ----------------------------------------
  // lock pin source select
  always_comb
  begin
    unique case (lock_sel_ff)
      `FND_LS_REF:  nxt_lock_pin = rdiv_lvl;
      `FND_LS_FB:   nxt_lock_pin = fb_wrap_ff;
      `FND_LS_TEST: nxt_lock_pin = modsel_ff;
      default:      nxt_lock_pin = locked_ff;
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lock_pin_ff <= 1'h0;
      swen_ff     <= 1'h0;
    end
    else
    begin
      lock_pin_ff <= nxt_lock_pin;
      swen_ff     <= sync_ff[2];
    end
  end

  assign hrdata_out             = hrdata_ff;
  assign hreadyout_out          = hreadyout_ff;
  assign hresp_out              = hresp_ff;
  assign modulus_select_out     = modsel_ff;
  assign prescaler_mode_out     = act_pmode_ff;
  assign rf_switch_on_out       = swen_ff;
  assign lock_indicator_pin_out = lock_pin_ff;

endmodule : fnd_feedback_divider

// ==== fnd_div_sva.sv ====
`timescale 1ns/1ps
module fnd_div_sva
(
  input wire logic        mclk_in,
  input wire logic        arst_n_in,
  input wire logic        hsel_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        ref_clk_in,
  input wire logic        presc_clk_in,
  input wire logic        output_switch_enable_in,
  input wire logic        modulus_select_out,
  input wire logic        prescaler_mode_out,
  input wire logic        rf_switch_on_out
);
  // ----------------------------------------
  // helper ages in clock cycles
  // ----------------------------------------
  logic [2:0] rst_age_ff;
  logic [2:0] ref_age_ff;
  logic [2:0] pre_age_ff;
  logic       ref_q_ff;
  logic       pre_q_ff;
  logic       rd_take;
  logic       wr_take;

  // cycles since reset and since raw pin rises, saturating at 7
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_age_ff <= 3'h0;
      ref_age_ff <= 3'h7;
      pre_age_ff <= 3'h7;
      ref_q_ff   <= 1'b0;
      pre_q_ff   <= 1'b0;
    end
    else
    begin
      rst_age_ff <= rst_age_ff + {2'h0, rst_age_ff != 3'h7};
      ref_age_ff <= (ref_clk_in && !ref_q_ff) ? 3'h0 : ref_age_ff + {2'h0, ref_age_ff != 3'h7};
      pre_age_ff <= (presc_clk_in && !pre_q_ff) ? 3'h0 : pre_age_ff + {2'h0, pre_age_ff != 3'h7};
      ref_q_ff   <= ref_clk_in;
      pre_q_ff   <= presc_clk_in;
    end
  end

  // bus request decode
  assign rd_take = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
  assign wr_take = hsel_in && hready_in && htrans_in[1] && hwrite_in;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_read_wait: assert property (rd_take |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  a_write_nowait: assert property (wr_take |=> hreadyout_out)
    else $error("write stalled");
  a_ready_pulse: assert property (!hreadyout_out |=> hreadyout_out)
    else $error("ready low too long");
  a_resp_okay: assert property (hresp_out == 1'b0)
    else $error("response not okay");
  a_rdata_hold: assert property ($changed(hrdata_out) |-> $past(hreadyout_out) == 1'b0)
    else $error("read data changed outside read");
  a_switch_follow: assert property (rst_age_ff == 3'h7 |->
    rf_switch_on_out == $past(output_switch_enable_in, 3))
    else $error("switch output lag wrong");
  a_modsel_edge: assert property ($changed(modulus_select_out) |-> pre_age_ff <= 3'h5)
    else $error("modulus select moved off prescaler edge");
  a_mode_at_ref: assert property ($changed(prescaler_mode_out) |-> ref_age_ff <= 3'h6)
    else $error("prescaler mode moved off reference edge");

  // main scenarios reached
  c_read: cover property (rd_take);
  c_upper: cover property ($rose(modulus_select_out));
  c_mode: cover property ($fell(prescaler_mode_out));
endmodule : fnd_div_sva

// ==== fnd_presc_model.sv ====
`timescale 1ns/1ps
module fnd_presc_model
(
  input  wire logic modsel_in,
  input  wire logic mode8_in,
  output logic      presc_clk_out,
  output int        periods_out,
  output int        upper_out
);
  int n;

  // oscillator of 40 ns divided by low or high ratio each period
  // periods_out counts oscillator periods, upper_out upper-ratio periods
  initial
  begin
    presc_clk_out = 1'b0;
    periods_out = 0;
    upper_out = 0;
    #3;
    forever
    begin
      n = (mode8_in === 1'b1) ? 8 : 16;
      if (modsel_in === 1'b1)
      begin
        n = n + 1;
        upper_out++;
      end
      presc_clk_out = 1'b1;
      periods_out += n;
      #(n * 20);
      presc_clk_out = 1'b0;
      #(n * 20);
    end
  end
endmodule : fnd_presc_model

// ==== fnd_feedback_divider_tb.sv ====
`timescale 1ns/1ps
module fnd_feedback_divider_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} fnd_row_s;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        ref_clk = 1'b0;
  logic        output_switch_enable = 1'b0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        presc_clk;
  logic        modsel;
  logic        mode8;
  logic        rf_on;
  logic        lp;
  logic        lpq;
  logic [31:0] rd_q;
  int          pcnt;
  int          hcnt;
  int          failures = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n;
  fnd_row_s    rows [11];

  // clocks: system 50 ns, free running reference 1 us, far below 25 MHz
  // host divisor fixed so the comparison rate suits the loop
  initial
  begin
    forever #25 mclk = ~mclk;
  end
  initial
  begin
    #7;
    forever #500 ref_clk = ~ref_clk;
  end

  fnd_feedback_divider u_fnd_feedback_divider (
    .mclk_in(mclk), .arst_n_in(arst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .ref_clk_in(ref_clk), .presc_clk_in(presc_clk), .output_switch_enable_in(output_switch_enable),
    .modulus_select_out(modsel), .prescaler_mode_out(mode8), .rf_switch_on_out(rf_on),
    .lock_indicator_pin_out(lp));

  fnd_presc_model u_fnd_presc_model (
    .modsel_in(modsel), .mode8_in(mode8), .presc_clk_out(presc_clk),
    .periods_out(pcnt), .upper_out(hcnt));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("counts: compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic chk_val(input logic [31:0] got, exp, msk, input string what);
    compares++;
    if ((got & msk) !== (exp & msk))
    begin
      failures++;
      $display("Error %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_rng(input int got, lo, hi, input string what);
    compares++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("Error %0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_rng

  // one single transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd_q = hrdata;
  endtask : ahb

  // program codes, then count oscillator periods between wrap pulses
  task automatic run_ratio(input logic [31:0] w2, w3, ctrl, st, input int ge, he);
    int p0;
    int h0;
    ahb(1'b1, 8'h00, 32'h00010000);
    ahb(1'b1, 8'h08, w2);
    ahb(1'b1, 8'h0C, w3);
    ahb(1'b1, 8'h10, ctrl);
    // new codes reach the counters only after the next reference tick
    repeat (200) @(posedge mclk);
    @(posedge lp);
    @(posedge lp);
    p0 = pcnt;
    h0 = hcnt;
    @(posedge lp);
    chk_rng(pcnt - p0, ge, ge, "total ratio");
    chk_rng(hcnt - h0, he, he, "upper periods");
    ahb(1'b0, 8'h14, 32'h0);
    chk_val(rd_q, st, 32'h00003FF2, "status loads");
    $display("ratio test done");
  endtask : run_ratio

  // watchdog
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      failures++;
      $display("Error %0t timeout", $time);
      stop_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rows = '{'{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b0, 8'h08, 32'h0, 32'h0004000C},
             '{1'b0, 8'h0C, 32'h0, 32'h0}, '{1'b0, 8'h10, 32'h0, 32'h00010000},
             '{1'b0, 8'h04, 32'h0, 32'h0}, '{1'b1, 8'h00, 32'hFFFFFFFF, 32'h00038000},
             '{1'b1, 8'h08, 32'hFFFFFFFF, 32'h00F4000C},
             '{1'b1, 8'h0C, 32'hFFFFFFFF, 32'h001FFFFC},
             '{1'b1, 8'h10, 32'hFFFFFFFF, 32'h000103FF},
             '{1'b1, 8'h18, 32'hFFFFFFFF, 32'h0}, '{1'b1, 8'h04, 32'hFFFFFFFF, 32'h0}};
    repeat (4) @(posedge mclk);
    chk_val({26'h0, hready, mode8, modsel, lp, rf_on, hresp}, 32'h30, 32'h3F, "reset");
    arst_n <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        ahb(1'b1, rows[i].a, rows[i].d);
      ahb(1'b0, rows[i].a, 32'h0);
      chk_val(rd_q, rows[i].e, 32'hFFFFFFFF, "register");
    end
    $display("register test done");
    // 8/9 integer, fourth high bit set and ignored
    run_ratio(32'h0000000C, 32'h0, 32'h00010238, 32'h2332, 283, 3);
    // 16/17 integer at the minimum ratio
    run_ratio(32'h0000000C, 32'h0, 32'h000000F0, 32'h0F30, 243, 3);
    // fractional mode, fraction one half
    run_ratio(32'h0004000C, 32'h00100000, 32'h00010238, 32'h2342, 284, 4);
    for (int k = 0; k < 4; k++)
    begin
      ahb(1'b1, 8'h08, {28'h0, k[1:0], 2'h0});
      ahb(1'b1, 8'h00, 32'h00008000);
      repeat (200) @(posedge mclk);
      n = 0;
      repeat (640)
      begin
        @(posedge mclk);
        if (lp === 1'b1 && lpq === 1'b0)
          n++;
        lpq = lp;
      end
      chk_rng(n, (32 >> k) - 1, (32 >> k) + 1, "reference divider");
    end
    $display("reference divider test done");
    ahb(1'b1, 8'h00, 32'h0);
    repeat (6000) @(posedge mclk);
    chk_val({31'h0, lp}, 32'h0, 32'h1, "lock pin unlocked");
    // ratio 200 at 40 ns matches the 8 us reference tick: 32 wraps per window
    ahb(1'b1, 8'h10, 32'h00010185);
    repeat (11000) @(posedge mclk);
    chk_val({31'h0, lp}, 32'h1, 32'h1, "lock pin locked");
    $display("lock test done");
    output_switch_enable <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_val({31'h0, rf_on}, 32'h1, 32'h1, "switch on");
    output_switch_enable <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_val({31'h0, rf_on}, 32'h0, 32'h1, "switch off");
    $display("switch test done");
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk_val({26'h0, hready, mode8, modsel, lp, rf_on, hresp}, 32'h30, 32'h3F, "reset");
    arst_n <= 1'b1;
    ahb(1'b0, 8'h08, 32'h0);
    chk_val(rd_q, 32'h0004000C, 32'hFFFFFFFF, "word 2 after reset");
    $display("second reset test done");
    stop_test();
  end
endmodule : fnd_feedback_divider_tb

bind fnd_feedback_divider fnd_div_sva u_fnd_div_sva (
  .mclk_in(mclk_in), .arst_n_in(arst_n_in), .hsel_in(hsel_in), .htrans_in(htrans_in),
  .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .ref_clk_in(ref_clk_in),
  .presc_clk_in(presc_clk_in), .output_switch_enable_in(output_switch_enable_in),
  .modulus_select_out(modulus_select_out), .prescaler_mode_out(prescaler_mode_out),
  .rf_switch_on_out(rf_switch_on_out));
